// *** core/ilcd_core.sv ***
// In-band loop code detectors with their register file, one framer
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Three detectors: up, down, spare
// - Pattern lengths one to eight, or sixteen
// - Detection runs only in T1 mode
// - Up/down lengths from shared length register
// - Spare uses own definitions and length
// - Sixteen bits joins both definition bytes
// - Short codes use first byte only
// - Framed or unframed, errors up to 1%
// - Tolerates inserted or overwriting framing bits
// - First-byte write restarts integration
// - Detect after 48 ms integration
// - Live bits plus latched set/clear bits
// - Per-bit interrupt mask for latched bits
// - Framer copies spaced by 200h
// - Latched bits clear on write one
module ilcd_core #(
  parameter int FRAMER_IDX = 1,
  parameter int INTEG_CYC  = ilcd_pkg::INTEG_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        line_clk,
  input  wire logic        line_data,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rd_data,
  output logic             irq,
  output logic             loop_up_detected,
  output logic             loop_down_detected,
  output logic             spare_code_detected
);

  // ----------------------------------------------------------------------
  // Framer placement
  // ----------------------------------------------------------------------
  // Per-framer base address
  localparam logic [11:0] BASE =
    12'(12'(FRAMER_IDX - 1) * ilcd_pkg::FRAMER_STRIDE);

  typedef struct packed {
    logic [7:0]  len_ctrl;
    logic [7:0]  up_d1;
    logic [7:0]  up_d2;
    logic [7:0]  dn_d1;
    logic [7:0]  dn_d2;
    logic [7:0]  sp_d1;
    logic [7:0]  sp_d2;
    logic [7:0]  sp_len;
    logic [7:0]  mask;
    logic [7:0]  latched;
    logic [2:0]  live_prev;
    logic        lclk_prev;
    logic [15:0] hist;
    logic [4:0]  fill;
    logic [7:0]  rd_data;
    logic        irq;
  } ilcd_core_st_t;

  ilcd_core_st_t st_q;
  ilcd_core_st_t st_d;

  logic [1:0]  pins_s;
  logic        bit_stb;
  logic        hist_full;
  logic        t1_en;
  logic [2:0]  det_vec;
  logic [2:0]  restart;
  logic [2:0]  rise;
  logic [2:0]  fall;
  logic [15:0] pat [3];
  logic [4:0]  len [3];
  logic        wr_lat;
  logic [7:0]  rd_val;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hits(input logic [11:0] a,
                                input logic [11:0] off);
    return a == 12'(BASE + off);
  endfunction

  function automatic logic [4:0] len_of(input logic [3:0] code);
    return code[ilcd_pkg::LEN16_BIT] ? 5'h10 : {2'b00, code[2:0]} + 5'h01;
  endfunction

  // Codes of eight bits or fewer use the first byte only; the second byte is ignored
  function automatic logic [15:0] pat_of(input logic [7:0] d1,
                                         input logic [7:0] d2,
                                         input logic [3:0] code);
    return code[ilcd_pkg::LEN16_BIT] ? {d1, d2} : {d1, 8'h00};
  endfunction

  // ----------------------------------------------------------------------
  // Line input
  // ----------------------------------------------------------------------
  // Line pins come from another domain, hence two stages first
  ilcd_sync #(
    .W (2)
  ) u_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .d_async ({line_clk, line_data}),
    .q       (pins_s)
  );

  assign bit_stb   = pins_s[1] & ~st_q.lclk_prev;
  assign hist_full = (st_q.fill == 5'h10);

  assign t1_en = st_q.sp_len[ilcd_pkg::T1_EN_BIT];

  // ----------------------------------------------------------------------
  // Pattern and length selection
  // ----------------------------------------------------------------------
  always_comb begin
    len[ilcd_pkg::DET_UP] =
      len_of(st_q.len_ctrl[ilcd_pkg::LEN_UP_LSB +: ilcd_pkg::LEN_W]);
    len[ilcd_pkg::DET_DN] =
      len_of(st_q.len_ctrl[ilcd_pkg::LEN_DN_LSB +: ilcd_pkg::LEN_W]);
    len[ilcd_pkg::DET_SP] = len_of(st_q.sp_len[ilcd_pkg::LEN_W-1:0]);
    pat[ilcd_pkg::DET_UP] = pat_of(st_q.up_d1, st_q.up_d2,
      st_q.len_ctrl[ilcd_pkg::LEN_UP_LSB +: ilcd_pkg::LEN_W]);
    pat[ilcd_pkg::DET_DN] = pat_of(st_q.dn_d1, st_q.dn_d2,
      st_q.len_ctrl[ilcd_pkg::LEN_DN_LSB +: ilcd_pkg::LEN_W]);
    pat[ilcd_pkg::DET_SP] = pat_of(st_q.sp_d1, st_q.sp_d2,
      st_q.sp_len[ilcd_pkg::LEN_W-1:0]);
  end

  always_comb begin
    restart[ilcd_pkg::DET_UP] = wr_stb && hits(addr, ilcd_pkg::OFF_UP_D1);
    restart[ilcd_pkg::DET_DN] = wr_stb && hits(addr, ilcd_pkg::OFF_DN_D1);
    restart[ilcd_pkg::DET_SP] =
      wr_stb && hits(addr, ilcd_pkg::OFF_SPARE_D1);
  end

  // ----------------------------------------------------------------------
  // Detectors
  // ----------------------------------------------------------------------
  // Three independent detectors
  for (genvar g = 0; g < ilcd_pkg::NUM_DET; g++) begin : g_det
    ilcd_det #(
      .INTEG_CYC (INTEG_CYC),
      .CNT_W     (ilcd_pkg::CNT_W)
    ) u_det (
      .clk       (clk),
      .rst_b     (rst_b),
      .ce        (ce),
      .enable    (t1_en),
      .restart   (restart[g]),
      .bit_stb   (bit_stb),
      .hist_full (hist_full),
      .hist      (st_q.hist),
      .pat       (pat[g]),
      .len       (len[g]),
      .detected  (det_vec[g])
    );
  end

  assign rise = det_vec & ~st_q.live_prev;
  assign fall = ~det_vec & st_q.live_prev;

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  assign wr_lat = wr_stb && hits(addr, ilcd_pkg::OFF_LATCHED);

  always_comb begin
    if (hits(addr, ilcd_pkg::OFF_LEN_CTRL)) begin
      rd_val = st_q.len_ctrl;
    end else if (hits(addr, ilcd_pkg::OFF_LATCHED)) begin
      rd_val = st_q.latched;
    end else if (hits(addr, ilcd_pkg::OFF_SPARE_D1)) begin
      rd_val = st_q.sp_d1;
    end else if (hits(addr, ilcd_pkg::OFF_SPARE_D2)) begin
      rd_val = st_q.sp_d2;
    end else if (hits(addr, ilcd_pkg::OFF_SPARE_LEN)) begin
      rd_val = st_q.sp_len;
    end else if (hits(addr, ilcd_pkg::OFF_MASK)) begin
      rd_val = st_q.mask;
    end else if (hits(addr, ilcd_pkg::OFF_UP_D1)) begin
      rd_val = st_q.up_d1;
    end else if (hits(addr, ilcd_pkg::OFF_UP_D2)) begin
      rd_val = st_q.up_d2;
    end else if (hits(addr, ilcd_pkg::OFF_DN_D1)) begin
      rd_val = st_q.dn_d1;
    end else if (hits(addr, ilcd_pkg::OFF_DN_D2)) begin
      rd_val = st_q.dn_d2;
    end else if (hits(addr, ilcd_pkg::OFF_LIVE)) begin
      rd_val = {5'h00, det_vec};
    end else begin
      rd_val = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.lclk_prev = pins_s[1];
    st_d.live_prev = det_vec;
    if (bit_stb) begin
      st_d.hist = {st_q.hist[14:0], pins_s[0]};
      if (!hist_full) begin
        st_d.fill = st_q.fill + 5'h01;
      end
    end
    if (wr_stb) begin
      if (hits(addr, ilcd_pkg::OFF_LEN_CTRL)) begin
        st_d.len_ctrl = wr_data;
      end else if (hits(addr, ilcd_pkg::OFF_SPARE_D1)) begin
        st_d.sp_d1 = wr_data;
      end else if (hits(addr, ilcd_pkg::OFF_SPARE_D2)) begin
        st_d.sp_d2 = wr_data;
      end else if (hits(addr, ilcd_pkg::OFF_SPARE_LEN)) begin
        st_d.sp_len = wr_data;
      end else if (hits(addr, ilcd_pkg::OFF_MASK)) begin
        st_d.mask = wr_data & ilcd_pkg::LAT_USED;
      end else if (hits(addr, ilcd_pkg::OFF_UP_D1)) begin
        st_d.up_d1 = wr_data;
      end else if (hits(addr, ilcd_pkg::OFF_UP_D2)) begin
        st_d.up_d2 = wr_data;
      end else if (hits(addr, ilcd_pkg::OFF_DN_D1)) begin
        st_d.dn_d1 = wr_data;
      end else if (hits(addr, ilcd_pkg::OFF_DN_D2)) begin
        st_d.dn_d2 = wr_data;
      end
    end
    if (wr_lat) begin
      st_d.latched = st_q.latched & ~wr_data;
    end
    st_d.latched[ilcd_pkg::LAT_SET_LSB +: 3] =
      st_d.latched[ilcd_pkg::LAT_SET_LSB +: 3] | rise;
    st_d.latched[ilcd_pkg::LAT_CLR_LSB +: 3] =
      st_d.latched[ilcd_pkg::LAT_CLR_LSB +: 3] | fall;
    st_d.latched = st_d.latched & ilcd_pkg::LAT_USED;
    st_d.irq = |(st_d.latched & st_d.mask);
    // Zero outside the answer cycle keeps stale data off the bus
    st_d.rd_data = rd_stb ? rd_val : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q          <= '0;
      st_q.len_ctrl <= ilcd_pkg::RST_LEN_CTRL;
      st_q.up_d1    <= ilcd_pkg::RST_DEF;
      st_q.up_d2    <= ilcd_pkg::RST_DEF;
      st_q.dn_d1    <= ilcd_pkg::RST_DEF;
      st_q.dn_d2    <= ilcd_pkg::RST_DEF;
      st_q.sp_d1    <= ilcd_pkg::RST_DEF;
      st_q.sp_d2    <= ilcd_pkg::RST_DEF;
      st_q.sp_len   <= ilcd_pkg::RST_SPARE_LEN;
      st_q.mask     <= ilcd_pkg::RST_MASK;
      st_q.latched  <= ilcd_pkg::RST_LATCHED;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign rd_data             = st_q.rd_data;
  assign irq                 = st_q.irq;
  assign loop_up_detected    = det_vec[ilcd_pkg::DET_UP];
  assign loop_down_detected  = det_vec[ilcd_pkg::DET_DN];
  assign spare_code_detected = det_vec[ilcd_pkg::DET_SP];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_live_read;
    @(posedge clk) disable iff (!rst_b)
      (ce && rd_stb && hits(addr, ilcd_pkg::OFF_LIVE))
        |=> (rd_data == {5'h00, $past(det_vec)});
  endproperty
  a_live_read: assert property (p_live_read)
    else $error("live status read mismatch");

  property p_w1c;
    @(posedge clk) disable iff (!rst_b)
      (ce && wr_lat && wr_data[0] && !rise[0]) |=> !st_q.latched[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("latched bit not cleared by write one");

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      (st_q.latched[0] && !(ce && wr_lat && wr_data[0]))
        |=> st_q.latched[0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("latched bit dropped without write");

  property p_set_edge;
    @(posedge clk) disable iff (!rst_b)
      (ce && rise[0]) |=> st_q.latched[ilcd_pkg::LAT_SET_LSB];
  endproperty
  a_set_edge: assert property (p_set_edge)
    else $error("rise not latched");

  property p_clr_edge;
    @(posedge clk) disable iff (!rst_b)
      (ce && fall[2]) |=> st_q.latched[ilcd_pkg::LAT_CLR_LSB + 2];
  endproperty
  a_clr_edge: assert property (p_clr_edge)
    else $error("fall not latched");

  property p_irq;
    @(posedge clk) disable iff (!rst_b)
      irq == |(st_q.latched & st_q.mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq disagrees with masked latched bits");

  property p_e1_off;
    @(posedge clk) disable iff (!rst_b)
      (ce && !t1_en) |=> (det_vec == 3'h0);
  endproperty
  a_e1_off: assert property (p_e1_off)
    else $error("detect active outside T1 mode");

endmodule : ilcd_core
`default_nettype wire

// *** core/ilcd_det.sv ***
// One repeating-pattern detector with its integration timer
`timescale 1ns/1ps
`default_nettype none
module ilcd_det #(
  parameter int INTEG_CYC = ilcd_pkg::INTEG_CYC,
  parameter int CNT_W     = ilcd_pkg::CNT_W
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        enable,
  input  wire logic        restart,
  input  wire logic        bit_stb,
  input  wire logic        hist_full,
  input  wire logic [15:0] hist,
  input  wire logic [15:0] pat,
  input  wire logic [4:0]  len,
  output logic             detected
);

  typedef struct packed {
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] tot;
    logic [CNT_W-1:0] bad;
    logic             det;
  } ilcd_det_st_t;

  ilcd_det_st_t st_q;
  ilcd_det_st_t st_d;
  logic         hit;
  logic         period_end;

  // ----------------------------------------------------------------------
  // Pattern match against every phase
  // ----------------------------------------------------------------------
  // Phase is unknown, so each rotation is tried; unused rotations never hit
  function automatic logic rot_match(input logic [15:0] h,
                                     input logic [15:0] p,
                                     input logic [4:0]  n);
    logic       any;
    logic       ok;
    logic [4:0] ph;
    any = 1'b0;
    for (int r = 0; r < 16; r++) begin
      ok = (5'(r) < n);
      ph = 5'(r);
      for (int a = 15; a >= 0; a--) begin
        if (h[a] != p[4'(5'd15 - ph)]) begin
          ok = 1'b0;
        end
        ph = (ph + 5'd1 == n) ? 5'd0 : ph + 5'd1;
      end
      if (ok) begin
        any = 1'b1;
      end
    end
    return any;
  endfunction

  assign hit        = rot_match(hist, pat, len);
  assign period_end = (st_q.tmr == CNT_W'(INTEG_CYC - 1));

  // ----------------------------------------------------------------------
  // Integration
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (!enable) begin
      st_d = '0;
    end else if (restart) begin
      st_d.tmr = '0;
      st_d.tot = '0;
      st_d.bad = '0;
    end else begin
      if (bit_stb && hist_full) begin
        st_d.tot = st_q.tot + 1'b1;
        if (!hit) begin
          st_d.bad = st_q.bad + 1'b1;
        end
      end
      if (period_end) begin
        // Half-window margin absorbs framing bits plus line errors
        st_d.det = (st_q.tot != '0) && ({st_q.bad, 1'b0} < {1'b0, st_q.tot});
        st_d.tmr = '0;
        st_d.tot = '0;
        st_d.bad = '0;
      end else begin
        st_d.tmr = st_q.tmr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign detected = st_q.det;

  property p_restart;
    @(posedge clk) disable iff (!rst_b)
      (ce && enable && restart) |=> (st_q.tmr == '0 && st_q.tot == '0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("integration not restarted");

  property p_integ;
    @(posedge clk) disable iff (!rst_b)
      $changed(detected) |-> ($past(period_end) || !$past(enable));
  endproperty
  a_integ: assert property (p_integ)
    else $error("detect changed outside period end");

endmodule : ilcd_det
`default_nettype wire

// *** core/ilcd_pkg.sv ***
// Constants shared by the in-band loop code detector files
package ilcd_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (first framer) and framer stride
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_LEN_CTRL  = 12'h082;
  localparam logic [11:0] OFF_LATCHED   = 12'h092;
  localparam logic [11:0] OFF_SPARE_D1  = 12'h09c;
  localparam logic [11:0] OFF_SPARE_D2  = 12'h09d;
  localparam logic [11:0] OFF_SPARE_LEN = 12'h09e;
  localparam logic [11:0] OFF_MASK      = 12'h0a2;
  localparam logic [11:0] OFF_UP_D1     = 12'h0ac;
  localparam logic [11:0] OFF_UP_D2     = 12'h0ad;
  localparam logic [11:0] OFF_DN_D1     = 12'h0ae;
  localparam logic [11:0] OFF_DN_D2     = 12'h0af;
  localparam logic [11:0] OFF_LIVE      = 12'h0b2;
  localparam logic [11:0] FRAMER_STRIDE = 12'h200;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int NUM_DET     = 3;
  localparam int DET_UP      = 0;
  localparam int DET_DN      = 1;
  localparam int DET_SP      = 2;
  localparam int LAT_SET_LSB = 0;
  localparam int LAT_CLR_LSB = 3;
  localparam int LEN_UP_LSB  = 0;
  localparam int LEN_DN_LSB  = 4;
  localparam int LEN_W       = 4;
  localparam int LEN16_BIT   = 3;
  localparam int T1_EN_BIT   = 7;
  localparam int HIST_W      = 16;
  localparam logic [7:0] LAT_USED = 8'h3f;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_DEF       = 8'h00;
  localparam logic [7:0] RST_LEN_CTRL  = 8'h00;
  localparam logic [7:0] RST_SPARE_LEN = 8'h80;
  localparam logic [7:0] RST_MASK      = 8'h00;
  localparam logic [7:0] RST_LATCHED   = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ    = 10_000_000;
  localparam int INTEG_MS  = 48;
  localparam int INTEG_CYC = INTEG_MS * (CLK_HZ / 1000);
  localparam int CNT_W     = 20;

endpackage : ilcd_pkg

// *** core/ilcd_sync.sv ***
// Two-stage synchroniser for line-side pins
`timescale 1ns/1ps
`default_nettype none
module ilcd_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ilcd_sync_st_t;

  ilcd_sync_st_t st_q;
  ilcd_sync_st_t st_d;

  // First stage feeds only the second
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d_async;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule : ilcd_sync
`default_nettype wire

// *** tb/ilcd_line_model.sv ***
// Far-end line source repeating a loop code, with errors and F-bits
`timescale 1ns/1ps
`default_nettype none
module ilcd_line_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        run,
  input  wire logic [15:0] pat,
  input  wire logic [4:0]  len,
  output logic             line_clk,
  output logic             line_data
);
  // ----------------------------------------------------------------
  // Bit sequencer, MSB of pat first, 8 clk per line bit
  // ----------------------------------------------------------------
  logic [1:0] div_q;
  logic [4:0] idx_q;
  logic [7:0] nbit_q;
  logic       fbit_q;
  logic       nxt;

  always_comb begin
    nxt = pat[5'd15 - idx_q];
    if (nbit_q == 8'd50 || nbit_q == 8'd150) begin
      nxt = ~nxt;
    end
    if (nbit_q == 8'd192) begin
      nxt = fbit_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !run) begin
      div_q    <= 2'd0;
      line_clk <= 1'b0;
      // Released line toggles so no stale level passes for data
      line_data <= rst_b ? ~line_data : 1'b0;
      if (!rst_b) begin
        idx_q  <= 5'd0;
        nbit_q <= 8'd0;
        fbit_q <= 1'b0;
      end
    end else begin
      div_q <= div_q + 2'd1;
      if (div_q == 2'd3) begin
        line_clk <= ~line_clk;
        if (line_clk) begin
          line_data <= nxt;
          idx_q     <= (idx_q + 5'd1 >= len) ? 5'd0 : idx_q + 5'd1;
          nbit_q    <= (nbit_q == 8'd192) ? 8'd0 : nbit_q + 8'd1;
          if (nbit_q == 8'd192) begin
            fbit_q <= ~fbit_q;
          end
        end
      end
    end
  end
endmodule // ilcd_line_model
`default_nettype wire

// *** tb/inband_loop_code_detector_test.sv ***
// Self-checking bench for the loop code detector core
`timescale 1ns/1ps
`default_nettype none
module inband_loop_code_detector_test;
  // ----------------------------------------------------------------
  // Settings, addresses and wiring
  // ----------------------------------------------------------------
  localparam int          FIDX  = 2;
  localparam int          INTEG = 2000;
  localparam logic [11:0] BASE  = 12'(FIDX - 1) * ilcd_pkg::FRAMER_STRIDE;
  localparam logic [11:0] A_LEN = BASE + ilcd_pkg::OFF_LEN_CTRL;
  localparam logic [11:0] A_SPL = BASE + ilcd_pkg::OFF_SPARE_LEN;
  localparam logic [11:0] A_MSK = BASE + ilcd_pkg::OFF_MASK;
  localparam logic [11:0] A_LAT = BASE + ilcd_pkg::OFF_LATCHED;
  localparam logic [11:0] A_LIV = BASE + ilcd_pkg::OFF_LIVE;

  logic        clk, rst_b, ce, line_clk, line_data, wr_stb, rd_stb, irq;
  logic        run;
  logic [11:0] addr;
  logic [7:0]  wr_data, rd_data;
  logic [15:0] pat;
  logic [4:0]  len;
  wire  [2:0]  det;
  int          errors, n_checks, n;

  ilcd_core #(.FRAMER_IDX(FIDX), .INTEG_CYC(INTEG)) i_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .line_clk(line_clk),
    .line_data(line_data), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .irq(irq),
    .loop_up_detected(det[0]), .loop_down_detected(det[1]),
    .spare_code_detected(det[2]));

  ilcd_line_model i_line (
    .clk(clk), .rst_b(rst_b), .run(run), .pat(pat), .len(len),
    .line_clk(line_clk), .line_data(line_data));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb  <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e, string nm);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(nm, e, rd_data);
  endtask

  // Bounded wait on one live detect output
  task automatic wait_det(input int w, input logic e, output int c);
    c = 0;
    while (det[w] !== e) begin
      @(posedge clk);
      #1;
      c++;
      if (c > 3 * INTEG) begin
        errors++;
        $display("FAIL det%0d expected %b seen %b", w, e, det[w]);
        final_report();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(A_LEN, 8'h00, "len_ctrl");
    rd(A_SPL, 8'h80, "spare_len");
    rd(A_MSK, 8'h00, "mask");
    rd(A_LAT, 8'h00, "latched");
    rd(A_LIV, 8'h00, "live");
    wr(ilcd_pkg::OFF_MASK, 8'h3f);
    rd(ilcd_pkg::OFF_MASK, 8'h00, "other_framer");
    rd(A_MSK, 8'h00, "mask_kept");
    // Frozen clock enable must swallow the strobe
    ce <= 1'b0;
    wr(A_MSK, 8'h3f);
    ce <= 1'b1;
    rd(A_MSK, 8'h00, "mask_ce_low");
  endtask

  task automatic t_up;
    wr(A_MSK, 8'h09);
    wr(A_LEN, 8'h04);
    pat <= 16'h8000;
    len <= 5'd5;
    run <= 1'b1;
    repeat (INTEG) @(posedge clk);
    wr(BASE + ilcd_pkg::OFF_UP_D1, 8'h80);
    wait_det(0, 1'b1, n);
    chk("up_not_early", 8'h01, {7'h0, n >= INTEG - 4});
    chk("up_not_late", 8'h01, {7'h0, n <= INTEG + 40});
    chk("others_idle", 8'h00, {5'h0, det[2:1]});
    rd(A_LIV, 8'h01, "live_up");
    rd(A_LAT, 8'h01, "lat_up_set");
    chk("irq_up", 8'h01, {7'h0, irq});
    wr(A_LAT, 8'h00);
    rd(A_LAT, 8'h01, "lat_zero_write");
    wr(A_LIV, 8'h00);
    rd(A_LIV, 8'h01, "live_write");
    wr(A_LAT, 8'h01);
    rd(A_LAT, 8'h00, "lat_cleared");
    chk("irq_cleared", 8'h00, {7'h0, irq});
    // Polling across a period end shows the code still present
    repeat (3) begin
      repeat (INTEG / 2) @(posedge clk);
      rd(A_LIV, 8'h01, "live_poll");
    end
  endtask

  task automatic t_fall;
    pat <= 16'hc000;
    len <= 5'd4;
    wait_det(0, 1'b0, n);
    rd(A_LAT, 8'h08, "lat_up_clr");
    chk("irq_fall", 8'h01, {7'h0, irq});
    wr(A_LAT, 8'h08);
    rd(A_LAT, 8'h00, "lat_clr_gone");
  endtask

  task automatic t_dn16;
    wr(BASE + ilcd_pkg::OFF_DN_D1, 8'ha5);
    wr(BASE + ilcd_pkg::OFF_DN_D2, 8'h3c);
    wr(A_LEN, 8'h84);
    pat <= 16'ha53c;
    len <= 5'd16;
    wait_det(1, 1'b1, n);
    rd(A_LIV, 8'h02, "live_dn16");
    rd(A_LAT, 8'h02, "lat_dn");
    chk("irq_masked", 8'h00, {7'h0, irq});
  endtask

  task automatic t_e1;
    int bad;
    bad = 0;
    wr(A_SPL, 8'h00);
    @(posedge clk);
    #1;
    chk("e1_off", 8'h00, {5'h0, det});
    repeat (2 * INTEG + 100) begin
      @(posedge clk);
      #1;
      if (det !== 3'b000) begin
        bad = 1;
      end
    end
    chk("e1_hold", 8'h00, 8'(bad));
    rd(A_LIV, 8'h00, "live_e1");
    wr(A_LAT, 8'h3f);
  endtask

  task automatic t_spare;
    wr(BASE + ilcd_pkg::OFF_SPARE_D1, 8'he4);
    wr(BASE + ilcd_pkg::OFF_SPARE_D2, 8'he4);
    wr(A_SPL, 8'h87);
    pat <= 16'he400;
    len <= 5'd8;
    wait_det(2, 1'b1, n);
    rd(A_LIV, 8'h04, "live_sp8");
    t_e1();
    wr(BASE + ilcd_pkg::OFF_SPARE_D1, 8'hc0);
    wr(BASE + ilcd_pkg::OFF_SPARE_D2, 8'h55);
    wr(A_SPL, 8'h82);
    pat <= 16'hc000;
    len <= 5'd3;
    wait_det(2, 1'b1, n);
    rd(A_LIV, 8'h04, "live_sp3");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b   = 1'b0;
    ce      = 1'b1;
    wr_stb  = 1'b0;
    rd_stb  = 1'b0;
    addr    = 12'h000;
    wr_data = 8'h00;
    run     = 1'b0;
    pat     = 16'h0000;
    len     = 5'd1;
    errors  = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_up();
    t_fall();
    t_dn16();
    t_e1();
    t_spare();
    final_report();
  end
endmodule // inband_loop_code_detector_test
`default_nettype wire
